/* File: design/port_pin_function_control.v */
// Port pin function control with AXI4-Lite register access
`timescale 1ns/1ps
`include "port_pin_map.vh"
module port_pin_function_control (
  input wire clk,
  input wire rst_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [71:0] pin_in,
  output wire [71:0] pin_out,
  output wire [71:0] pin_oe,
  output wire [71:0] pull_up_en,
  output wire [71:0] pull_dn_en,
  input wire [2:0] ser_txd,
  input wire [2:0] ser_clk_out,
  input wire [2:0] ser_clk_master,
  output wire [2:0] ser_rxd,
  output wire [2:0] ser_clk_in,
  input wire [1:0] tw_data_out,
  input wire [1:0] tw_clock_out,
  output wire [1:0] tw_data_in,
  output wire [1:0] tw_clock_in,
  input wire [4:0] tmr_out,
  output wire [4:0] tmr_event_in,
  input wire remote_carrier,
  input wire piezo_tone,
  output wire [2:0] piezo_freq_sel
);

// ======================================================================
// Register storage
reg [7:0] data_r [0:`NUM_PORTS-1];
reg [7:0] dir_r [0:`NUM_PORTS-1];
reg [7:0] pull_r [0:`NUM_PORTS-1];
reg [7:0] drive_r [0:`NUM_PORTS-1];
reg [7:0] alt_r [0:`NUM_PORTS-1];
reg [`NUM_PULL_SEL_PORTS-1:0] pull_polarity_select_reg;
reg [7:0] osc_wait_ctrl_reg;
reg [2:0] ser_mode_r [0:`NUM_SER_CH-1];
wire [71:0] pin_sync;
reg [71:0] alt_sel;
reg [71:0] alt_val;
wire [71:0] dir_flat;
wire [71:0] drive_flat;
wire wr_go;
wire rd_go;
reg [31:0] rd_data_nxt;
reg rd_ok_nxt;
integer k;

// ======================================================================
// Address decode
function [7:0] port_mask;
  input [3:0] idx;
  begin
    case (idx)
      4'h0: port_mask = 8'hFF >> (8 - `P3_WIDTH);
      4'h1: port_mask = 8'hFF >> (8 - `P4_WIDTH);
      4'h2: port_mask = 8'hFF >> (8 - `P5_WIDTH);
      4'h3: port_mask = 8'hFF >> (8 - `P6_WIDTH);
      4'h4: port_mask = 8'hFF >> (8 - `P7_WIDTH);
      4'h5: port_mask = 8'hFF >> (8 - `P8_WIDTH);
      4'h6: port_mask = 8'hFF >> (8 - `P9_WIDTH);
      4'h7: port_mask = 8'hFF >> (8 - `PA_WIDTH);
      4'h8: port_mask = 8'hFF >> (8 - `PB_WIDTH);
      default: port_mask = 8'h00;
    endcase
  end
endfunction

function port_hit;
  input [11:0] addr;
  begin
    port_hit = (addr < `PORT_REGION_END) && (addr[4:2] <= `FLD_INPUT)
      && (addr[1:0] == 2'h0);
  end
endfunction

function mode_hit;
  input [11:0] addr;
  begin
    mode_hit = (addr >= `GLB_SER_MODE_BASE)
      && (addr <= `GLB_SER_MODE_LAST) && (addr[1:0] == 2'h0);
  end
endfunction

// ======================================================================
// AXI4-Lite write channel, address and data taken together
assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign rd_go = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_arready = rd_go;

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    for (k = 0; k < `NUM_PORTS; k = k + 1) begin
      data_r[k] <= `RST_PORT_REG;
      dir_r[k] <= `RST_PORT_REG;
      pull_r[k] <= `RST_PORT_REG;
      drive_r[k] <= `RST_PORT_REG;
      alt_r[k] <= `RST_PORT_REG;
    end
    for (k = 0; k < `NUM_SER_CH; k = k + 1) begin
      ser_mode_r[k] <= 3'h0;
    end
    pull_polarity_select_reg <= 5'h00;
    osc_wait_ctrl_reg <= `RST_GLB_REG;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
  end else begin
    if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
    if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= `RESP_OKAY;
      if (port_hit(s_axi_awaddr)) begin
        if (s_axi_wstrb[0]) begin
          case (s_axi_awaddr[4:2])
            `FLD_DATA: data_r[s_axi_awaddr[8:5]] <= s_axi_wdata[7:0]
              & port_mask(s_axi_awaddr[8:5]);
            `FLD_DIR: dir_r[s_axi_awaddr[8:5]] <= s_axi_wdata[7:0]
              & port_mask(s_axi_awaddr[8:5]);
            `FLD_PULL: pull_r[s_axi_awaddr[8:5]] <= s_axi_wdata[7:0]
              & port_mask(s_axi_awaddr[8:5]);
            `FLD_DRIVE: drive_r[s_axi_awaddr[8:5]] <= s_axi_wdata[7:0]
              & port_mask(s_axi_awaddr[8:5]);
            `FLD_ALT: alt_r[s_axi_awaddr[8:5]] <= s_axi_wdata[7:0]
              & port_mask(s_axi_awaddr[8:5]);
            default: ;
          endcase
        end
      end else if (s_axi_awaddr == `GLB_PULL_POL) begin
        if (s_axi_wstrb[0]) begin
          pull_polarity_select_reg <= s_axi_wdata[4:0];
        end
      end else if (s_axi_awaddr == `GLB_OSC_WAIT) begin
        if (s_axi_wstrb[0]) begin
          osc_wait_ctrl_reg <= {4'h0, s_axi_wdata[3:0]};
        end
      end else if (mode_hit(s_axi_awaddr)) begin
        if (s_axi_wstrb[0]) begin
          ser_mode_r[s_axi_awaddr[3:2] - 2'h2] <= s_axi_wdata[2:0];
        end
      end else begin
        s_axi_bresp <= `RESP_SLVERR;
      end
    end
  end
end

// ======================================================================
// AXI4-Lite read channel, answer one cycle after the address
always @* begin
  rd_data_nxt = 32'h0000_0000;
  rd_ok_nxt = 1'b1;
  if (port_hit(s_axi_araddr)) begin
    case (s_axi_araddr[4:2])
      `FLD_DATA: rd_data_nxt[7:0] = data_r[s_axi_araddr[8:5]];
      `FLD_DIR: rd_data_nxt[7:0] = dir_r[s_axi_araddr[8:5]];
      `FLD_PULL: rd_data_nxt[7:0] = pull_r[s_axi_araddr[8:5]];
      `FLD_DRIVE: rd_data_nxt[7:0] = drive_r[s_axi_araddr[8:5]];
      `FLD_ALT: rd_data_nxt[7:0] = alt_r[s_axi_araddr[8:5]];
      `FLD_INPUT: rd_data_nxt[7:0] = pin_sync[s_axi_araddr[8:5]*8 +: 8]
        & port_mask(s_axi_araddr[8:5]);
      default: rd_data_nxt = 32'h0000_0000;
    endcase
  end else if (s_axi_araddr == `GLB_PULL_POL) begin
    rd_data_nxt[4:0] = pull_polarity_select_reg;
  end else if (s_axi_araddr == `GLB_OSC_WAIT) begin
    rd_data_nxt[7:0] = osc_wait_ctrl_reg;
  end else if (mode_hit(s_axi_araddr)) begin
    rd_data_nxt[2:0] = ser_mode_r[s_axi_araddr[3:2] - 2'h2];
  end else begin
    rd_ok_nxt = 1'b0;
  end
end

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `RESP_OKAY;
  end else begin
    if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
    if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_nxt;
      s_axi_rresp <= rd_ok_nxt ? `RESP_OKAY : `RESP_SLVERR;
    end
  end
end

// ======================================================================
// Pin input synchronisation
pin_sync2 #(
  .WIDTH(72)
) i_pin_sync2 (
  .clk(clk),
  .rst_n(rst_n),
  .d(pin_in),
  .q(pin_sync)
);

// ======================================================================
// Alternate function routing
always @* begin
  alt_sel = 72'h0;
  alt_val = 72'h0;
  // Serial 0 and 2: UART or synchronous transmit, clock only as master
  alt_sel[`PIN_S0_TX] = ser_mode_r[0][`MODE_SYNC_OUT]
    | ser_mode_r[0][`MODE_UART];
  alt_val[`PIN_S0_TX] = ser_txd[0];
  alt_sel[`PIN_S0_CLK] = ser_mode_r[0][`MODE_SYNC_OUT]
    & ser_clk_master[0];
  alt_val[`PIN_S0_CLK] = ser_clk_out[0];
  alt_sel[`PIN_S2_TX] = ser_mode_r[1][`MODE_SYNC_OUT]
    | ser_mode_r[1][`MODE_UART];
  alt_val[`PIN_S2_TX] = ser_txd[1];
  alt_sel[`PIN_S2_CLK] = ser_mode_r[1][`MODE_SYNC_OUT]
    & ser_clk_master[1];
  alt_val[`PIN_S2_CLK] = ser_clk_out[1];
  // Serial 4 shares its pins between sync serial and two-wire
  if (ser_mode_r[2][`MODE_TWO_WIRE]) begin
    // Two-wire refuses push-pull so a driven one can never fight the bus
    alt_sel[`PIN_S4_DATA] = drive_r[3][`PIN_S4_DATA-24];
    alt_val[`PIN_S4_DATA] = tw_data_out[0];
    alt_sel[`PIN_S4_CLK] = drive_r[3][`PIN_S4_CLK-24];
    alt_val[`PIN_S4_CLK] = tw_clock_out[0];
  end else begin
    alt_sel[`PIN_S4_DATA] = ser_mode_r[2][`MODE_SYNC_OUT];
    alt_val[`PIN_S4_DATA] = ser_txd[2];
    alt_sel[`PIN_S4_CLK] = ser_mode_r[2][`MODE_SYNC_OUT]
      & ser_clk_master[2];
    alt_val[`PIN_S4_CLK] = ser_clk_out[2];
  end
  alt_sel[`PIN_S5_DATA] = ser_mode_r[3][`MODE_TWO_WIRE]
    & drive_r[4][`PIN_S5_DATA-32];
  alt_val[`PIN_S5_DATA] = tw_data_out[1];
  alt_sel[`PIN_S5_CLK] = ser_mode_r[3][`MODE_TWO_WIRE]
    & drive_r[4][`PIN_S5_CLK-32];
  alt_val[`PIN_S5_CLK] = tw_clock_out[1];
  // Timer outputs; bit 0 carries the remote carrier when buzzer selected
  alt_sel[`PIN_TMR_BASE +: 5] = alt_r[7][4:0];
  alt_val[`PIN_TMR_BASE +: 5] = tmr_out;
  if (osc_wait_ctrl_reg[`OSC_BUZ_SEL]) begin
    alt_val[`PIN_TMR_BASE] = remote_carrier;
  end
  alt_sel[`PIN_BUZ_TRUE] = alt_r[2][`PIN_BUZ_TRUE-16]
    & osc_wait_ctrl_reg[`OSC_BUZ_SEL];
  alt_val[`PIN_BUZ_TRUE] = piezo_tone;
  alt_sel[`PIN_BUZ_INV] = alt_r[2][`PIN_BUZ_INV-16]
    & osc_wait_ctrl_reg[`OSC_BUZ_SEL];
  alt_val[`PIN_BUZ_INV] = ~piezo_tone;
end

// ======================================================================
// Per-port pad control
genvar g;
generate
  for (g = 0; g < `NUM_PORTS; g = g + 1) begin : gen_port
    wire pol_g;
    assign dir_flat[g*8 +: 8] = dir_r[g];
    // Ports 8 to B have no drive choice and pull up only
    assign drive_flat[g*8 +: 8] =
      (g < `NUM_PULL_SEL_PORTS) ? drive_r[g] : 8'h00;
    // Split so the upper ports never index past the polarity bits
    if (g < `NUM_PULL_SEL_PORTS) begin : gen_sel
      assign pol_g = pull_polarity_select_reg[g];
    end else begin : gen_up
      assign pol_g = 1'b1;
    end
    port_pin_cell i_port_pin_cell (
      .clk(clk),
      .rst_n(rst_n),
      .dir(dir_r[g]),
      .open_drain(drive_flat[g*8 +: 8]),
      .data(data_r[g]),
      .alt_sel(alt_sel[g*8 +: 8]),
      .alt_val(alt_val[g*8 +: 8]),
      .pull_en(pull_r[g]),
      .pull_up_pol(pol_g),
      .pin_out(pin_out[g*8 +: 8]),
      .pin_oe(pin_oe[g*8 +: 8]),
      .pull_up(pull_up_en[g*8 +: 8]),
      .pull_dn(pull_dn_en[g*8 +: 8])
    );
  end
endgenerate

// ======================================================================
// Synchronised pin levels toward the peripheral cores
assign ser_rxd = {pin_sync[`PIN_S4_RX], pin_sync[`PIN_S2_RX],
  pin_sync[`PIN_S0_RX]};
assign ser_clk_in = {pin_sync[`PIN_S4_CLK], pin_sync[`PIN_S2_CLK],
  pin_sync[`PIN_S0_CLK]};
assign tw_data_in = {pin_sync[`PIN_S5_DATA], pin_sync[`PIN_S4_DATA]};
assign tw_clock_in = {pin_sync[`PIN_S5_CLK], pin_sync[`PIN_S4_CLK]};
// Event count sees nothing while the bit is an output
assign tmr_event_in = pin_sync[`PIN_TMR_BASE +: 5]
  & ~dir_flat[`PIN_TMR_BASE +: 5];
assign piezo_freq_sel = osc_wait_ctrl_reg[`OSC_FREQ_MSB:`OSC_FREQ_LSB];

endmodule

/* File: design/port_pin_map.vh */
// Register map, field positions and pin routing for the port block
// Operation
// - Every port bit is set input or output by its own direction bit.
// - Port 3 has three bits, port 4 five, port 5 eight.
// - Port 6 has seven bits, port 9 six, port B four.
// - Ports 3 to 7 enable a pull resistor per bit.
// - Ports 3 to 7 choose pull-up or pull-down per whole port.
// - Ports 8, 9, A and B offer per-bit pull-up only.
// - After reset every bit is input with pulls off, high impedance.
// - Serial pins choose push-pull or open-drain per pin by drive register.
// - Serial data or clock reaches a pin only with output and serial mode.
// - Serial channels 0 to 2 in UART mode use transmit and receive pins; Serial 4 here transmits in sync mode only, not in UART mode.
// - Two-wire channels 4 and 5 use open-drain bidirectional data and clock.
// - Timer event counting needs the bit set as input; pull-up optional.
// - Timer output needs special function selected and direction output.
// - Remote carrier needs special function, output and buzzer select.
// - Port 5 buzzer pair needs special function, output and buzzer select.
// - Without an alternate function a pin is an ordinary port bit.
`ifndef PORT_PIN_MAP_VH
`define PORT_PIN_MAP_VH

// ======================================================================
// Ports: index 0..8 are ports 3,4,5,6,7,8,9,A,B
`define NUM_PORTS 9
`define NUM_PULL_SEL_PORTS 5
`define P3_WIDTH 3
`define P4_WIDTH 5
`define P5_WIDTH 8
`define P6_WIDTH 7
`define P7_WIDTH 8
`define P8_WIDTH 8
`define P9_WIDTH 6
`define PA_WIDTH 8
`define PB_WIDTH 4

// ======================================================================
// Per-port registers at port index * 0x20 plus field offset
`define FLD_DATA 3'h0
`define FLD_DIR 3'h1
`define FLD_PULL 3'h2
`define FLD_DRIVE 3'h3
`define FLD_ALT 3'h4
`define FLD_INPUT 3'h5
`define PORT_REGION_END 12'h120

// ======================================================================
// Global registers
`define GLB_PULL_POL 12'h200
`define GLB_OSC_WAIT 12'h204
`define GLB_SER_MODE_BASE 12'h208
`define GLB_SER_MODE_LAST 12'h214
`define NUM_SER_CH 4

// ======================================================================
// Field positions and reset values
`define MODE_SYNC_OUT 0
`define MODE_UART 1
`define MODE_TWO_WIRE 2
`define OSC_BUZ_SEL 0
`define OSC_FREQ_LSB 1
`define OSC_FREQ_MSB 3
`define RST_PORT_REG 8'h00
`define RST_GLB_REG 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ======================================================================
// Pin positions on the flat 72-bit pin bus, port index * 8 + bit
`define PIN_S0_TX 16
`define PIN_S0_RX 17
`define PIN_S0_CLK 18
`define PIN_BUZ_TRUE 19
`define PIN_BUZ_INV 20
`define PIN_S4_RX 28
`define PIN_S4_DATA 29
`define PIN_S4_CLK 30
`define PIN_S2_TX 32
`define PIN_S2_RX 33
`define PIN_S2_CLK 34
`define PIN_S5_DATA 35
`define PIN_S5_CLK 36
`define PIN_TMR_BASE 56

`endif

/* File: design/pin_sync2.v */
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module pin_sync2 #(
  parameter WIDTH = 72
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta_r;

// ======================================================================
// First stage is read only by the second
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    meta_r <= {WIDTH{1'b0}};
    q <= {WIDTH{1'b0}};
  end else begin
    meta_r <= d;
    q <= meta_r;
  end
end

endmodule

/* File: design/port_pin_cell.v */
// Output drive and pull control for one eight-bit port
`timescale 1ns/1ps
module port_pin_cell (
  input wire clk,
  input wire rst_n,
  input wire [7:0] dir,
  input wire [7:0] open_drain,
  input wire [7:0] data,
  input wire [7:0] alt_sel,
  input wire [7:0] alt_val,
  input wire [7:0] pull_en,
  input wire pull_up_pol,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  output reg [7:0] pull_up,
  output reg [7:0] pull_dn
);

wire [7:0] level;

assign level = (alt_sel & alt_val) | (~alt_sel & data);

// ======================================================================
// Registered pad controls
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    pin_out <= 8'h00;
    pin_oe <= 8'h00;
    pull_up <= 8'h00;
    pull_dn <= 8'h00;
  end else begin
    // Open-drain never drives high, it only releases
    pin_out <= level & ~open_drain;
    pin_oe <= dir & ~(open_drain & level);
    pull_up <= pull_en & {8{pull_up_pol}};
    pull_dn <= pull_en & {8{~pull_up_pol}};
  end
end

endmodule

/* File: testbench/port_pin_function_control_asserts.sv */
// Concurrent checks on the port pin function control block
`timescale 1ns/1ps
module port_pin_function_control_asserts (
  input wire clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [71:0] pin_in,
  input wire [71:0] pin_oe,
  input wire [71:0] pull_up_en,
  input wire [71:0] pull_dn_en,
  input wire [2:0] ser_rxd,
  input wire [4:0] tmr_event_in
);
  // Bits that the narrow ports lack
  localparam logic [71:0] ABSENT = 72'hF000C000008000E0F8;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ======================================================================
  // Bus handshake
  a_write_accept: assert property (
    s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write accept out of step");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");

  // ======================================================================
  // Pins
  a_reset_quiet: assert property (
    $rose(rst_n) |-> (pin_oe | pull_up_en | pull_dn_en) == 72'h0)
    else $error("pin driven or pulled after reset");
  a_pull_exclusive: assert property (
    (pull_up_en & pull_dn_en) == 72'h0)
    else $error("pull-up and pull-down together");
  a_upper_up_only: assert property (
    pull_dn_en[71:40] == 32'h0)
    else $error("pull-down on upper ports");
  a_absent_bits: assert property (
    ((pin_oe | pull_up_en | pull_dn_en) & ABSENT) == 72'h0)
    else $error("missing port bit active");
  a_input_sync: assert property (
    $past(rst_n, 2) |-> ser_rxd[0] == $past(pin_in[17], 2))
    else $error("receive level not two cycles late");
  a_event_input: assert property (
    tmr_event_in[0] |=> !pin_oe[56])
    else $error("event input while pin drives");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_event: cover property (tmr_event_in[0]);
endmodule

bind port_pin_function_control port_pin_function_control_asserts
  i_port_pin_function_control_asserts (.*);

/* File: testbench/board_model.sv */
// Board model: resolves each pin from chip, outside drive and pulls
`timescale 1ns/1ps
module board_model (
  input wire clk,
  input wire [71:0] pin_out,
  input wire [71:0] pin_oe,
  input wire [71:0] pull_up_en,
  input wire [71:0] pull_dn_en,
  input wire [71:0] ext_oe,
  input wire [71:0] ext_val,
  output logic [71:0] pin_in
);
  // ======================================================================
  // Pin resolution
  // Floating pins wander so a stale level is never trusted
  logic [71:0] drift = 72'h0;
  always @(posedge clk) drift <= ~drift;
  always_comb begin
    for (int i = 0; i < 72; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_oe[i] ? ext_val[i] :
        pull_up_en[i] ? 1'h1 : pull_dn_en[i] ? 1'h0 : drift[i];
    end
  end
endmodule

/* File: testbench/port_pin_function_control_tb.sv */
// Self-checking bench for the port pin function control block
`timescale 1ns/1ps
module port_pin_function_control_tb;
  // ======================================================================
  // Signals
  logic clk = 1'h0, rst_n = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] ser_txd = 3'h0, ser_clk_out = 3'h0, ser_clk_master = 3'h0;
  logic [1:0] tw_data_out = 2'h3, tw_clock_out = 2'h3;
  logic [4:0] tmr_out = 5'h00;
  logic remote_carrier = 1'h0, piezo_tone = 1'h0;
  logic [71:0] ext_oe = 72'h0, ext_val = 72'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, tw_data_in, tw_clock_in;
  wire [31:0] s_axi_rdata;
  wire [71:0] pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en;
  wire [2:0] ser_rxd, ser_clk_in, piezo_freq_sel;
  wire [4:0] tmr_event_in;
  int fail_count = 0, n_checks = 0;
  int wd[9] = '{3, 5, 8, 7, 8, 8, 6, 8, 4};

  port_pin_function_control i_port_pin_function_control (.*);
  board_model i_board_model (.*);

  initial begin
    forever #25 clk = ~clk;
  end

  // ======================================================================
  // Shared tasks
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [71:0] g, input logic [71:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Bounded waits: a hung handshake ends the run
  task automatic tmo(input int n);
    if (n >= 40) begin
      fail_count++;
      $display("ERROR %0t: bus wait ran out", $time);
      end_of_test();
    end
  endtask

  function automatic logic [11:0] ra(input int p, input int f);
    return 12'(p * 32 + f * 4);
  endfunction

  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] e = 2'h0);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    @(negedge clk);
    for (n = 0; n < 40 && s_axi_awready !== 1'h1; n++) @(negedge clk);
    tmo(n);
    @(posedge clk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    @(negedge clk);
    for (n = 0; n < 40 && s_axi_bvalid !== 1'h1; n++) @(negedge clk);
    tmo(n);
    chk(s_axi_bresp, e);
    // Late ready makes the slave hold its answer one cycle
    @(posedge clk);
    s_axi_bready <= 1'h1;
    @(posedge clk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] e = 2'h0);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    @(negedge clk);
    for (n = 0; n < 40 && s_axi_arready !== 1'h1; n++) @(negedge clk);
    tmo(n);
    @(posedge clk);
    s_axi_arvalid <= 1'h0;
    @(negedge clk);
    for (n = 0; n < 40 && s_axi_rvalid !== 1'h1; n++) @(negedge clk);
    tmo(n);
    chk({s_axi_rresp, s_axi_rdata}, {e, 24'h0, d});
    @(posedge clk);
    s_axi_rready <= 1'h1;
    @(posedge clk);
    s_axi_rready <= 1'h0;
  endtask

  // ======================================================================
  // Scenarios
  task automatic t_reset;
    @(negedge clk);
    chk(pin_oe | pull_up_en | pull_dn_en, 72'h0);
    rd(ra(2, 1), 8'h00);
    wr(12'h300, 8'h55, 2'h2);
    rd(12'h300, 8'h00, 2'h2);
  endtask

  task automatic t_ports;
    logic [7:0] m;
    for (int p = 0; p < 9; p++) begin
      m = 8'hFF >> (8 - wd[p]);
      wr(ra(p, 0), 8'h3C);
      wr(ra(p, 1), 8'hA5);
      settle();
      chk(pin_oe[p*8 +: 8], m & 8'hA5);
      chk(pin_out[p*8 +: 8] & pin_oe[p*8 +: 8], m & 8'h24);
      rd(ra(p, 1), m & 8'hA5);
      wr(ra(p, 1), 8'h00);
    end
  endtask

  task automatic t_pull;
    wr(12'h200, 8'h01);
    wr(ra(0, 2), 8'h05);
    settle();
    chk({pull_up_en[7:0], pull_dn_en[7:0]}, 16'h0500);
    wr(12'h200, 8'h00);
    settle();
    chk({pull_up_en[7:0], pull_dn_en[7:0]}, 16'h0005);
    wr(ra(5, 2), 8'h81);
    settle();
    chk({pull_up_en[47:40], pull_dn_en[47:40]}, 16'h8100);
    wr(ra(0, 2), 8'h00);
    wr(ra(5, 2), 8'h00);
  endtask

  task automatic t_drive;
    wr(ra(4, 3), 8'h80);
    wr(ra(4, 1), 8'h80);
    wr(ra(4, 0), 8'h80);
    settle();
    chk(pin_oe[39], 1'h0);
    wr(ra(4, 0), 8'h00);
    settle();
    chk({pin_oe[39], pin_out[39]}, 2'h2);
    wr(ra(4, 3), 8'h00);
    wr(ra(4, 0), 8'h80);
    settle();
    chk({pin_oe[39], pin_out[39]}, 2'h3);
    wr(ra(4, 1), 8'h00);
  endtask

  task automatic t_input;
    logic [7:0] b;
    for (int k = 0; k < 2; k++) begin
      b = k ? 8'hC3 : 8'h3C;
      @(posedge clk);
      ext_oe <= {72{1'h1}};
      ext_val <= {9{b}};
      settle();
      chk({ser_rxd[0], tmr_event_in[0]}, {b[1], b[0]});
      chk({ser_rxd, ser_clk_in, tw_data_in, tw_clock_in, tmr_event_in},
        {b[4], b[1], b[1], b[6], b[2], b[2], b[3], b[5], b[4], b[6],
        b[4:0]});
      rd(ra(2, 5), b);
    end
    wr(ra(7, 0), 8'h01);
    wr(ra(7, 1), 8'h01);
    settle();
    chk(tmr_event_in[0], 1'h0);
    wr(ra(7, 1), 8'h00);
    @(posedge clk);
    ext_oe <= 72'h0;
  endtask

  task automatic t_serial;
    @(posedge clk);
    ser_clk_out <= 3'h1;
    ser_clk_master <= 3'h1;
    wr(ra(2, 0), 8'h01);
    wr(ra(2, 1), 8'h05);
    for (int k = 0; k < 3; k++) begin
      wr(12'h208, 8'h02 >> k);
      settle();
      chk(pin_out[16], k == 2);
      if (k == 1) chk(pin_out[18], 1'h1);
    end
    wr(ra(2, 1), 8'h00);
    wr(ra(3, 3), 8'h20);
    wr(ra(3, 1), 8'h20);
    wr(12'h210, 8'h04);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      tw_data_out <= {1'h1, k[0]};
      settle();
      chk({pin_oe[29], pin_out[29]}, {~k[0], 1'h0});
    end
  endtask

  task automatic t_timer;
    wr(ra(7, 0), 8'h00);
    wr(ra(7, 4), 8'h01);
    wr(ra(7, 1), 8'h01);
    for (int s = 0; s < 2; s++) begin
      wr(12'h204, s ? 8'h0B : 8'h00);
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        tmr_out <= {4'h0, k[0]};
        remote_carrier <= ~k[0];
        settle();
        chk(pin_out[56], k[0] ^ s[0]);
      end
    end
    wr(ra(2, 4), 8'h18);
    wr(ra(2, 1), 8'h18);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      piezo_tone <= k[0];
      settle();
      chk({pin_out[20:19], piezo_freq_sel}, {~k[0], k[0], 3'h5});
    end
  endtask

  // Reset again with pins driven and pulled, all must fall quiet
  task automatic t_rerst;
    wr(ra(1, 2), 8'h1F);
    settle();
    chk(pull_dn_en[15:8], 8'h1F);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    chk(pin_oe | pull_up_en | pull_dn_en, 72'h0);
    rd(ra(1, 2), 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_ports();
    t_pull();
    t_drive();
    t_input();
    t_serial();
    t_timer();
    t_rerst();
    end_of_test();
  end
endmodule
